// *** dv/cam_dec_mdl.sv ***
/* apb master standing in for the cpu instruction decoder.
   assumes pready from the block; hangs are cut by the bench. */
`timescale 1ns/1ns
module cam_dec_mdl (
  // clock
  input  wire logic        pclk,
  // apb request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  // apb answer
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // ---------------------------------------------------------------
  // transfer
  // ---------------------------------------------------------------
  // bus idle from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end

  // setup, then access held until pready high; afterwards address and data show
  // inverted values so a stale address never passes for a fresh one
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : cam_dec_mdl

// *** dv/tb.sv ***
/* self-checking bench of the cpu datapath block over apb.
   assumes the register map and command layout of cam_pkg. */
`timescale 1ns/1ns
module tb;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        pclk, presetn, psel, penable, pwrite;
  logic        pready, pslverr, busy, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [15:0] cpu_status_word;
  int          err_total = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          run = 0;
  int          last_run = 0;

  // 20 mhz clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  cam_alu cam_alu_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .busy,
    .cpu_status_word);
  cam_dec_mdl cam_dec_mdl_i (.pclk, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr);

  // busy run length; hang limit far above the few hundred cycles used
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (busy === 1'b1) run <= run + 1;
    else if (run != 0) begin
      last_run <= run;
      run <= 0;
    end
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] s, x);
    total_checks++;
    if (s !== x) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    cam_dec_mdl_i.xfer(1'b1, a, d, rv, er);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    cam_dec_mdl_i.xfer(1'b0, a, 32'h0, rv, er);
  endtask : rd

  function automatic logic [11:0] wa(input int i);
    return 12'h040 + 12'(i * 4);
  endfunction : wa

  task automatic setw(input int i, input logic [15:0] v);
    wr(wa(i), {16'h0, v});
  endtask : setw

  // command word: op, {dsm,srm,byte}, sub, ws, wb, wd, literal
  function automatic logic [31:0] mk(input logic [3:0] o,
      input logic [2:0] f, s, input logic [3:0] a, b, d,
      input logic [5:0] l);
    return {4'h0, s, l, d, b, a, f, o};
  endfunction : mk

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    rd(cam_pkg::ADDR_STAT);
    chk("status at reset", rv, 32'h0);
    rd(12'h100);
    chk("unmapped refused", {31'h0, er}, 32'h1);
  endtask : t_reset

  // logic ops keep carry, overflow and digit carry of the op before
  task automatic t_arith();
    logic [67:0] t [9] = '{
      {4'h0, 16'h00ff, 16'h0001, 16'h0100, 16'h0100},
      {4'h0, 16'hffff, 16'h0001, 16'h0000, 16'h0103},
      {4'h1, 16'h0000, 16'h0001, 16'hffff, 16'h0008},
      {4'h1, 16'h8000, 16'h0001, 16'h7fff, 16'h0005},
      {4'h1, 16'h0010, 16'h0001, 16'h000f, 16'h0101},
      {4'h0, 16'h7fff, 16'h0001, 16'h8000, 16'h010c},
      {4'h2, 16'hf0f0, 16'hff00, 16'hf000, 16'h010c},
      {4'h3, 16'hf0f0, 16'hff00, 16'hfff0, 16'h010c},
      {4'h4, 16'hf0f0, 16'hff00, 16'h0ff0, 16'h0104}};
    for (int i = 0; i < 9; i++) begin
      setw(2, t[i][63:48]);
      setw(3, t[i][47:32]);
      wr(cam_pkg::ADDR_CMD, mk(t[i][67:64], 3'h0, 3'h0, 4'h2, 4'h3,
         4'h4, 6'h0));
      rd(wa(4));
      chk("result", rv, {16'h0, t[i][31:16]});
      rd(cam_pkg::ADDR_STAT);
      chk("flags", rv, {16'h0, t[i][15:0]});
    end
  endtask : t_arith

  task automatic t_modes();
    setw(4, 16'hab0f);
    setw(5, 16'h0001);
    setw(6, 16'h5500);
    wr(cam_pkg::ADDR_CMD, mk(4'h0, 3'h1, 3'h0, 4'h4, 4'h5, 4'h6, 6'h0));
    rd(wa(6));
    chk("byte sum", rv, 32'h5510);
    rd(cam_pkg::ADDR_STAT);
    chk("byte flags", rv, 32'h0100);
    wr(12'h08c, 32'h7000);
    wr(cam_pkg::ADDR_CMD, mk(4'h0, 3'h6, 3'h0, 4'h3, 4'h5, 4'h9, 6'h0));
    rd(12'h0a4);
    chk("memory sum", rv, 32'h7001);
    wr(cam_pkg::ADDR_CMD, mk(4'h5, 3'h2, 3'h0, 4'h3, 4'h0, 4'h7, 6'h4));
    rd(wa(7));
    chk("memory shift", rv, 32'h0700);
  endtask : t_modes

  // amounts: +4, +4 arith, -4, 0, +16, +16 arith, -16
  task automatic t_shift();
    logic [24:0] t [7] = '{{6'h04, 3'h0, 16'h0842},
      {6'h04, 3'h1, 16'hf842}, {6'h3c, 3'h0, 16'h4210},
      {6'h00, 3'h0, 16'h8421}, {6'h10, 3'h0, 16'h0000},
      {6'h10, 3'h1, 16'hffff}, {6'h30, 3'h0, 16'h0000}};
    setw(2, 16'h8421);
    for (int i = 0; i < 7; i++) begin
      wr(cam_pkg::ADDR_CMD, mk(4'h5, 3'h0, t[i][18:16], 4'h2, 4'h0,
         4'h3, t[i][24:19]));
      rd(wa(3));
      chk("shift", rv, {16'h0, t[i][15:0]});
    end
  endtask : t_shift

  // operands 0xffff and 0xfffe, literal 3, every sub-mode
  task automatic t_mul();
    logic [34:0] t [7] = '{{3'h0, 32'h00000002},
      {3'h1, 32'hfffd0002}, {3'h2, 32'hfffe0002},
      {3'h3, 32'hffff0002}, {3'h4, 32'hfffffffd},
      {3'h5, 32'h0002fffd}, {3'h6, 32'h0000fd02}};
    setw(2, 16'hffff);
    setw(3, 16'hfffe);
    for (int i = 0; i < 7; i++) begin
      wr(cam_pkg::ADDR_CMD, mk(4'h6, 3'h0, t[i][34:32], 4'h2, 4'h3,
         4'h4, 6'h03));
      rd(wa(4));
      chk("product low", rv, {16'h0, t[i][15:0]});
      rd(wa(5));
      if (i < 6) chk("product high", rv, {16'h0, t[i][31:16]});
    end
  endtask : t_mul

  // dividend pair w3:w2 (w2 alone in sub-modes 2 and 3), divisor w8; a write during the run is refused
  task automatic t_div();
    logic [82:0] t [4] = '{
      {3'h0, 16'hffff, 16'hfff9, 16'h0002, 16'hfffd, 16'hffff},
      {3'h1, 16'h0001, 16'h0000, 16'h0003, 16'h5555, 16'h0001},
      {3'h2, 16'h0001, 16'hfff9, 16'h0002, 16'hfffd, 16'hffff},
      {3'h3, 16'h0001, 16'hfff9, 16'h0002, 16'h7ffc, 16'h0001}};
    for (int i = 0; i < 4; i++) begin
      setw(2, t[i][63:48]);
      setw(3, t[i][79:64]);
      setw(8, t[i][47:32]);
      wr(cam_pkg::ADDR_CMD, mk(4'h7, 3'h0, t[i][82:80], 4'h2, 4'h8,
         4'h0, 6'h0));
      wr(wa(0), 32'h1234);
      chk("locked write", {31'h0, er}, 32'h1);
      for (int k = 0; k < 40 && busy === 1'b1; k++) @(posedge pclk);
      rd(wa(0));
      chk("quotient", rv, {16'h0, t[i][31:16]});
      rd(wa(1));
      chk("remainder", rv, {16'h0, t[i][15:0]});
      chk("divide cycles", last_run, cam_pkg::DIV_TOTAL);
    end
  endtask : t_div

  // ---------------------------------------------------------------
  // sequence and verdict
  // ---------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test

  initial begin
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_arith();
    t_modes();
    t_shift();
    t_mul();
    t_div();
    end_of_test();
  end
endmodule : tb

// *** hdl/cam_alu.sv ***
/*
 * cpu integer datapath: add, subtract, logic, one-cycle shifter,
 * 17x17 multiplier and iterative divider, with the working register
 * array, a small data memory and the status word, all over apb.
 * assumes one clock pclk, asynchronous active-low presetn, and a
 * master that keeps to the apb protocol.
 */
`timescale 1ns/1ns

module cam_alu (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // state for the decoder
  output logic             busy,
  output logic      [15:0] cpu_status_word
);

  // -----------------------------------------------------------------
  // storage
  // -----------------------------------------------------------------
  logic [15:0] w_ff [16];
  logic [15:0] dm_ff [16];
  logic [15:0] stat_ff;
  logic [31:0] rdat_ff;
  logic        err_ff;
  cam_pkg::cam_dvst_t dv_ff;
  logic [16:0] rem_ff;
  logic [15:0] quo_ff, dvs_ff;
  logic [31:0] dd_ff;
  logic        dsgn_ff, qneg_ff, rneg_ff;
  logic [4:0]  cnt_ff;

  // -----------------------------------------------------------------
  // apb decode
  // -----------------------------------------------------------------
  // region: 0 none, 1 command, 2 status, 3 wregs, 4 data memory
  function automatic logic [2:0] region(input logic [11:0] a);
    if (a[1:0] != 2'h0) region = 3'h0;
    else if (a == cam_pkg::ADDR_CMD) region = 3'h1;
    else if (a == cam_pkg::ADDR_STAT) region = 3'h2;
    else if (a[11:6] == cam_pkg::PAGE_WREG) region = 3'h3;
    else if (a[11:6] == cam_pkg::PAGE_DMEM) region = 3'h4;
    else region = 3'h0;
  endfunction : region

  logic [2:0] rgn;
  logic       setup, wr_ok, cmd_go;
  assign rgn    = region(paddr);
  assign setup  = psel & ~penable;
  assign wr_ok  = psel & penable & pwrite & ~err_ff;
  assign busy   = (dv_ff != cam_pkg::DV_IDLE);
  assign pready = 1'b1;  // zero wait states, answer prepared at setup
  assign prdata  = rdat_ff;
  assign pslverr = err_ff & psel & penable;
  assign cpu_status_word = stat_ff;

  // read data and error are settled in the setup cycle; writes to the
  // command, wregs or memory are refused while a divide runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdat_ff <= 32'h0000_0000;
      err_ff  <= 1'b0;
    end else if (setup) begin
      err_ff  <= (rgn == 3'h0) | (busy & pwrite & (rgn != 3'h2));
      if (rgn == 3'h2)
        rdat_ff <= {15'h0000, busy, stat_ff};
      else if (rgn == 3'h3)
        rdat_ff <= {16'h0000, w_ff[paddr[5:2]]};
      else if (rgn == 3'h4)
        rdat_ff <= {16'h0000, dm_ff[paddr[5:2]]};
      else
        rdat_ff <= 32'h0000_0000;
    end
  end

  // -----------------------------------------------------------------
  // command fields and operands
  // -----------------------------------------------------------------
  cam_pkg::cam_op_t op;
  logic        byt, srm, dsm;
  logic [3:0]  ws, wb, wd;
  logic [5:0]  lit;
  logic [2:0]  sub;
  logic [15:0] opa, opb;
  assign cmd_go = wr_ok & (rgn == 3'h1) & ~busy;
  assign op  = cam_cast_op(pwdata[cam_pkg::CMD_OP +: 4]);
  assign byt = pwdata[cam_pkg::CMD_BYT];
  assign srm = pwdata[cam_pkg::CMD_SRM];
  assign dsm = pwdata[cam_pkg::CMD_DSM];
  assign ws  = pwdata[cam_pkg::CMD_WS +: 4];
  assign wb  = pwdata[cam_pkg::CMD_WB +: 4];
  assign wd  = pwdata[cam_pkg::CMD_WD +: 4];
  assign lit = pwdata[cam_pkg::CMD_LIT +: 6];
  assign sub = pwdata[cam_pkg::CMD_SUB +: 3];
  assign opa = srm ? dm_ff[ws] : w_ff[ws];
  assign opb = w_ff[wb];

  function automatic cam_pkg::cam_op_t cam_cast_op(input logic [3:0] v);
    cam_cast_op = cam_pkg::cam_op_t'(v);
  endfunction : cam_cast_op

  // -----------------------------------------------------------------
  // adder, logic and shifter
  // -----------------------------------------------------------------
  logic        is_sub, arith, sneg;
  logic [15:0] bb, res;
  logic [16:0] sum;
  logic [8:0]  lo8;
  logic [4:0]  lo4;
  logic [5:0]  mag;
  logic [31:0] src32, shr, shl;
  logic        c_o, v_o, dcy;
  assign is_sub = (op == cam_pkg::OP_SUB);
  assign bb  = is_sub ? ~opb : opb;  // a + ~b + 1, carry set = no borrow
  assign sum = {1'b0, opa} + {1'b0, bb} + {16'h0000, is_sub};
  assign lo8 = {1'b0, opa[7:0]} + {1'b0, bb[7:0]} + {8'h00, is_sub};
  assign lo4 = {1'b0, opa[3:0]} + {1'b0, bb[3:0]} + {4'h0, is_sub};
  assign dcy = byt ? lo4[4] : lo8[8];
  assign c_o = byt ? lo8[8] : sum[16];
  assign v_o = byt ? (opa[7] == bb[7]) & (sum[7] != opa[7])
                   : (opa[15] == bb[15]) & (sum[15] != opa[15]);
  // shifter: sign of the amount picks direction, magnitude the count
  assign arith = sub[0];
  assign sneg  = lit[5];
  assign mag   = sneg ? 6'(-lit) : lit;
  assign src32 = byt ? {{24{arith & opa[7]}}, opa[7:0]}
                     : {{16{arith & opa[15]}}, opa};
  assign shr   = src32 >> mag;  // single cycle barrel
  assign shl   = src32 << mag;  // zero amount passes src

  always_comb begin
    case (op)
      cam_pkg::OP_ADD, cam_pkg::OP_SUB: res = sum[15:0];
      cam_pkg::OP_AND: res = opa & opb;
      cam_pkg::OP_IOR: res = opa | opb;
      cam_pkg::OP_XOR: res = opa ^ opb;
      cam_pkg::OP_SHF: res = sneg ? shl[15:0] : shr[15:0];
      default:         res = 16'h0000;
    endcase
  end

  logic alu_op, res_z, res_n;
  assign alu_op = cmd_go & (op <= cam_pkg::OP_SHF);
  assign res_z  = byt ? (res[7:0] == 8'h00) : (res == 16'h0000);
  assign res_n  = byt ? res[7] : res[15];

  // -----------------------------------------------------------------
  // multiplier: both operands widened to 17 bits, signed array
  // -----------------------------------------------------------------
  logic        sa, sb;
  logic [16:0] ma, mb;
  logic [33:0] prod;
  cam_pkg::cam_mul_t mm;
  assign mm = cam_pkg::cam_mul_t'(sub);
  assign sa = (mm == cam_pkg::MUL_SS) | (mm == cam_pkg::MUL_SU)
            | (mm == cam_pkg::MUL_SL);
  assign sb = (mm == cam_pkg::MUL_SS) | (mm == cam_pkg::MUL_US);
  always_comb begin
    if (mm == cam_pkg::MUL_B8) begin
      ma = {9'h000, opa[7:0]};
      mb = {9'h000, opb[7:0]};
    end else if (mm == cam_pkg::MUL_SL || mm == cam_pkg::MUL_UL) begin
      ma = {sa & opa[15], opa};
      mb = {12'h000, lit[4:0]};
    end else begin
      ma = {sa & opa[15], opa};
      mb = {sb & opb[15], opb};
    end
  end
  assign prod = 34'($signed(ma) * $signed(mb));

  // -----------------------------------------------------------------
  // divider sequencer: load, 16 steps, sign fix, write back
  // -----------------------------------------------------------------
  logic [31:0] dd_in, ddmag;
  logic [15:0] dvmag;
  logic [16:0] trial;
  logic        dvneg;
  // aligned pair, odd register holds the upper half
  assign dd_in = sub[1]
      ? (sub[0] ? {16'h0000, w_ff[ws]} : {{16{w_ff[ws]
          [15]}}, w_ff[ws]})
      : {w_ff[{ws[3:1], 1'b1}], w_ff[{ws[3:1], 1'b0}]};
  assign dvneg = dsgn_ff & dvs_ff[15];
  assign ddmag = (dsgn_ff & dd_ff[31]) ? 32'(-dd_ff) : dd_ff;
  assign dvmag = dvneg ? 16'(-dvs_ff) : dvs_ff;
  assign trial = {rem_ff[15:0], quo_ff[15]};

  // partial quotient and remainder live only here and the wregs are
  // locked by the bus decode, so nothing can disturb them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dv_ff   <= cam_pkg::DV_IDLE;
      rem_ff  <= 17'h00000;
      quo_ff  <= 16'h0000;
      dvs_ff  <= 16'h0000;
      dd_ff   <= 32'h0000_0000;
      dsgn_ff <= 1'b0;
      qneg_ff <= 1'b0;
      rneg_ff <= 1'b0;
      cnt_ff  <= 5'h00;
    end else begin
      case (dv_ff)
        cam_pkg::DV_IDLE: if (cmd_go && op == cam_pkg::OP_DIV) begin
          dd_ff   <= dd_in;
          dvs_ff  <= opb;  // any divisor register
          dsgn_ff <= ~sub[0];
          dv_ff   <= cam_pkg::DV_LOAD;
        end
        cam_pkg::DV_LOAD: begin
          qneg_ff <= (dsgn_ff & dd_ff[31]) ^ dvneg;
          rneg_ff <= dsgn_ff & dd_ff[31];
          rem_ff  <= {1'b0, ddmag[31:16]};
          quo_ff  <= ddmag[15:0];
          dvs_ff  <= dvmag;
          cnt_ff  <= cam_pkg::DIV_STEPS;
          dv_ff   <= cam_pkg::DV_ITER;
        end
        cam_pkg::DV_ITER: begin  // restoring step per bit
          if (trial >= {1'b0, dvs_ff}) begin
            rem_ff <= trial - {1'b0, dvs_ff};
            quo_ff <= {quo_ff[14:0], 1'b1};
          end else begin
            rem_ff <= trial;
            quo_ff <= {quo_ff[14:0], 1'b0};
          end
          cnt_ff <= cnt_ff - 5'h01;
          if (cnt_ff == 5'h01)
            dv_ff <= cam_pkg::DV_FIX;
        end
        cam_pkg::DV_FIX: begin
          quo_ff <= qneg_ff ? 16'(-quo_ff) : quo_ff;
          rem_ff <= rneg_ff ? 17'(-rem_ff) : rem_ff;
          dv_ff  <= cam_pkg::DV_WB;
        end
        default: dv_ff <= cam_pkg::DV_IDLE;  // write-back cycle
      endcase
    end
  end

  // -----------------------------------------------------------------
  // working register array and data memory
  // -----------------------------------------------------------------
  logic is_mul;
  assign is_mul = cmd_go & (op == cam_pkg::OP_MUL);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 16; i++)
        w_ff[i] <= 16'h0000;
    end else if (wr_ok && rgn == 3'h3) begin
      w_ff[paddr[5:2]] <= pwdata[15:0];
    end else if (alu_op && !dsm) begin
      if (byt)
        w_ff[wd][7:0] <= res[7:0];  // upper byte kept
      else
        w_ff[wd] <= res;
    end else if (is_mul && mm == cam_pkg::MUL_B8) begin
      w_ff[wd] <= prod[15:0];
    end else if (is_mul) begin  // low word to even register
      w_ff[{wd[3:1], 1'b0}] <= prod[15:0];
      w_ff[{wd[3:1], 1'b1}] <= prod[31:16];
    end else if (dv_ff == cam_pkg::DV_WB) begin
      w_ff[0] <= quo_ff;
      w_ff[1] <= rem_ff[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 16; i++)
        dm_ff[i] <= 16'h0000;
    end else if (wr_ok && rgn == 3'h4) begin
      dm_ff[paddr[5:2]] <= pwdata[15:0];
    end else if (alu_op && dsm) begin
      if (byt)
        dm_ff[wd][7:0] <= res[7:0];
      else
        dm_ff[wd] <= res;
    end
  end

  // -----------------------------------------------------------------
  // status word
  // -----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_ff <= cam_pkg::FLG_RESET;
    end else if (wr_ok && rgn == 3'h2) begin
      stat_ff <= pwdata[15:0] & cam_pkg::FLG_MASK;
    end else if (alu_op) begin
      stat_ff[cam_pkg::FLG_ZERO] <= res_z;
      stat_ff[cam_pkg::FLG_NEG]  <= res_n;
      if (op == cam_pkg::OP_ADD || is_sub) begin
        stat_ff[cam_pkg::FLG_CARRY] <= c_o;
        stat_ff[cam_pkg::FLG_OVF]   <= v_o;
        stat_ff[cam_pkg::FLG_DIGC]  <= dcy;
      end
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  logic [15:0] ck_a, ck_b;
  logic [3:0]  ck_wd;
  logic [4:0]  ck_dn;
  logic        ck_add, ck_sub, ck_mul, ck_ub, ck_sh0;
  logic [5:0]  ck_sh;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {ck_a, ck_b, ck_wd, ck_sh} <= 42'h0;
      {ck_add, ck_sub, ck_mul, ck_ub, ck_sh0} <= 5'h00;
      ck_dn <= 5'h00;
    end else begin
      ck_a   <= opa;
      ck_b   <= opb;
      ck_wd  <= wd;
      ck_sh  <= lit;
      ck_add <= alu_op & (op == cam_pkg::OP_ADD) & ~byt & ~dsm;
      ck_sub <= alu_op & is_sub & ~byt & ~dsm;
      ck_ub  <= alu_op & (op == cam_pkg::OP_ADD) & byt & ~dsm;
      ck_mul <= is_mul & (mm == cam_pkg::MUL_UU);
      ck_sh0 <= alu_op & (op == cam_pkg::OP_SHF) & ~byt & ~dsm
              & ~sub[0];
      ck_dn  <= busy ? ck_dn + 5'h01 : 5'h00;
    end
  end

  property p_add;
    @(posedge pclk) disable iff (!presetn)
    ck_add |-> {stat_ff[cam_pkg::FLG_CARRY], w_ff[ck_wd]}
               == {1'b0, ck_a} + {1'b0, ck_b};
  endproperty
  a_add: assert property (p_add) else $error("add result");
  property p_sub;
    @(posedge pclk) disable iff (!presetn)
    ck_sub |-> stat_ff[cam_pkg::FLG_CARRY] == (ck_a >= ck_b);
  endproperty
  a_sub: assert property (p_sub) else $error("borrow");
  property p_digc;
    @(posedge pclk) disable iff (!presetn)
    ck_add |-> stat_ff[cam_pkg::FLG_DIGC]
               == (({1'b0, ck_a[7:0]} + {1'b0, ck_b[7:0]}) > 9'h0ff);
  endproperty
  a_digc: assert property (p_digc) else $error("digit carry");
  property p_byte;
    @(posedge pclk) disable iff (!presetn)
    ck_ub |-> w_ff[ck_wd][15:8] == $past(w_ff[ck_wd][15:8]);
  endproperty
  a_byte: assert property (p_byte) else $error("high byte");
  property p_mul;
    @(posedge pclk) disable iff (!presetn)
    ck_mul |-> {w_ff[{ck_wd[3:1], 1'b1}], w_ff[{ck_wd[3:1], 1'b0}]}
               == 32'(ck_a * ck_b);
  endproperty
  a_mul: assert property (p_mul) else $error("product");
  property p_shift;
    @(posedge pclk) disable iff (!presetn)
    ck_sh0 && !ck_sh[5] |-> w_ff[ck_wd] == 16'(ck_a >> ck_sh);
  endproperty
  a_shift: assert property (p_shift) else $error("right shift");
  property p_shz;
    @(posedge pclk) disable iff (!presetn)
    ck_sh0 && ck_sh == 6'h00 |-> w_ff[ck_wd] == ck_a;
  endproperty
  a_shz: assert property (p_shz) else $error("zero shift");
  property p_divlen;
    @(posedge pclk) disable iff (!presetn)
    $fell(busy) |-> $past(ck_dn) == 5'(DIV_TOTAL - 1);
  endproperty
  localparam int DIV_TOTAL = cam_pkg::DIV_TOTAL;
  a_divlen: assert property (p_divlen) else $error("divide time");
  property p_divwb;
    @(posedge pclk) disable iff (!presetn)
    dv_ff == cam_pkg::DV_WB |=> w_ff[0] == $past(quo_ff) ##0
                               w_ff[1] == $past(rem_ff[15:0]);
  endproperty
  a_divwb: assert property (p_divwb) else $error("divide result");

  c_div: cover property (@(posedge pclk) disable iff (!presetn)
    $fell(busy));
  c_mul: cover property (@(posedge pclk) disable iff (!presetn) ck_mul);
  c_left: cover property (@(posedge pclk) disable iff (!presetn)
    ck_sh0 && ck_sh[5]);

endmodule : cam_alu

// *** hdl/cam_pkg.sv ***
/*
 * constants, field layouts and types of the cpu alu, multiplier,
 * divider and shifter block.
 * assumes an apb master with 32-bit data and a 12-bit byte address.
 */
package cam_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] ADDR_CMD  = 12'h000;
  localparam logic [11:0] ADDR_STAT = 12'h004;
  localparam logic [5:0]  PAGE_WREG = 6'h01;  // 0x040..0x07c
  localparam logic [5:0]  PAGE_DMEM = 6'h02;  // 0x080..0x0bc

  // ---------------------------------------------------------------
  // command word fields
  // ---------------------------------------------------------------
  localparam int CMD_OP  = 0;   // 4 bits
  localparam int CMD_BYT = 4;
  localparam int CMD_SRM = 5;   // source from data memory
  localparam int CMD_DSM = 6;   // add, sub, logic and shift result to data memory
  localparam int CMD_WS  = 7;   // 4 bits, source / dividend
  localparam int CMD_WB  = 11;  // 4 bits, second operand / divisor
  localparam int CMD_WD  = 15;  // 4 bits, destination
  localparam int CMD_LIT = 19;  // 6 bits, shift amount or literal
  localparam int CMD_SUB = 25;  // 3 bits, sub-mode

  // ---------------------------------------------------------------
  // status word bit positions and reset value
  // ---------------------------------------------------------------
  localparam int FLG_CARRY = 0;
  localparam int FLG_ZERO  = 1;
  localparam int FLG_OVF   = 2;
  localparam int FLG_NEG   = 3;
  localparam int FLG_DIGC  = 8;
  localparam int STAT_BUSY = 16;
  localparam logic [15:0] FLG_MASK  = 16'h010f;
  localparam logic [15:0] FLG_RESET = 16'h0000;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam logic [4:0] DIV_STEPS = 5'h10;  // one per divisor bit
  localparam int         DIV_TOTAL = 19;     // busy cycles of a divide

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_ADD = 4'h0, OP_SUB = 4'h1, OP_AND = 4'h2, OP_IOR = 4'h3,
    OP_XOR = 4'h4, OP_SHF = 4'h5, OP_MUL = 4'h6, OP_DIV = 4'h7
  } cam_op_t;

  typedef enum logic [2:0] {
    MUL_SS = 3'h0, MUL_UU = 3'h1, MUL_US = 3'h2, MUL_SU = 3'h3,
    MUL_SL = 3'h4, MUL_UL = 3'h5, MUL_B8 = 3'h6
  } cam_mul_t;

  // divide sub-mode: bit1 = 16-bit dividend, bit0 = unsigned
  typedef enum logic [2:0] {
    DIV_L_S = 3'h0, DIV_L_U = 3'h1, DIV_W_S = 3'h2, DIV_W_U = 3'h3
  } cam_div_t;

  typedef enum logic [2:0] {
    DV_IDLE = 3'h0, DV_LOAD = 3'h1, DV_ITER = 3'h2,
    DV_FIX  = 3'h3, DV_WB   = 3'h4
  } cam_dvst_t;

endpackage : cam_pkg
